// [rtl/bha_consts.svh]
// constants of the bus handoff arbiter
// assumes nothing beyond a single 100 MHz clock
`ifndef BHA_CONSTS_SVH
`define BHA_CONSTS_SVH

`define BHA_OUT_W        9
`define BHA_OUT_S0       9'h040
`define BHA_OUT_S1       9'h1a0
`define BHA_OUT_S2       9'h190
`define BHA_OUT_S3       9'h188
`define BHA_OUT_S4       9'h184
`define BHA_OUT_S5       9'h082
`define BHA_OUT_S6       9'h081
`define BHA_OUT_RST      9'h040
`define BHA_BIT_AWARD    8
`define BHA_BIT_FLOAT    7
`define BHA_BIT_FLAG0    6
`define BHA_BIT_FLAG1    5
`define BHA_BIT_FLAG2    4
`define BHA_BIT_FLAG3    3
`define BHA_BIT_FLAG4    2
`define BHA_BIT_FLAG5    1
`define BHA_BIT_FLAG6    0
`define BHA_CLK_PERIOD_NS 10
`define BHA_STEP_NS      40
`define BHA_STEP_CYC     ((`BHA_STEP_NS + `BHA_CLK_PERIOD_NS - 1) / `BHA_CLK_PERIOD_NS)

`endif

// [rtl/bha_pkg.sv]
// types of the bus handoff arbiter
// assumes bha_consts.svh sits beside it
package bha_pkg;
  // gray walk s0 s1 s2 s6 s5 s4 s3 along the usual path
  typedef enum logic [2:0] {
    BHA_S0 = 3'h0,
    BHA_S1 = 3'h1,
    BHA_S2 = 3'h3,
    BHA_S6 = 3'h2,
    BHA_S5 = 3'h6,
    BHA_S4 = 3'h7,
    BHA_S3 = 3'h5
  } bha_state_t;

  typedef struct packed {
    bha_state_t  state;
    logic [8:0]  word;
  } bha_core_t;

  typedef struct packed {
    logic [1:0]  cnt;
  } bha_tick_t;
endpackage

// [rtl/bha_step_gen.sv]
// step enable divider for the bus handoff arbiter
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
`include "bha_consts.svh"

module bha_step_gen
  import bha_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // enable out
  output logic      step_en
);

  localparam logic [1:0] LAST = 2'(`BHA_STEP_CYC - 1);

  bha_tick_t s_q;
  bha_tick_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == LAST) begin
      s_d.cnt = 2'h0;
    end else begin
      s_d.cnt = s_q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_en = (s_q.cnt == LAST);

endmodule // bha_step_gen

// [rtl/bha_arbiter.sv]
// seven-state bus handoff arbiter with registered output word
// assumes request and confirm are synchronous to clk
`timescale 1ns/100ps
`include "bha_consts.svh"

module bha_arbiter
  import bha_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // master handshake
  input  wire logic bus_want_in,
  input  wire logic master_confirm_in,
  // grant and host float
  output logic      bus_award_out,
  output logic      host_float_out,
  // state indicators
  output logic      phase_flag_0,
  output logic      phase_flag_1,
  output logic      phase_flag_2,
  output logic      phase_flag_3,
  output logic      phase_flag_4,
  output logic      phase_flag_5,
  output logic      phase_flag_6
);

  ////////////////////////////////////////////////////////////////////////
  // step enable

  logic      step_en;

  bha_step_gen u_step (
    .clk     (clk),
    .rst_n   (rst_n),
    .step_en (step_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // output word loaded on entry to a state
  function automatic logic [8:0] word_of(input bha_state_t s);
    logic [8:0] w;
    w = `BHA_OUT_S0;
    case (s)
      BHA_S0: begin
        w = `BHA_OUT_S0;
      end
      BHA_S1: begin
        w = `BHA_OUT_S1;
      end
      BHA_S2: begin
        w = `BHA_OUT_S2;
      end
      BHA_S3: begin
        w = `BHA_OUT_S3;
      end
      BHA_S4: begin
        w = `BHA_OUT_S4;
      end
      BHA_S5: begin
        w = `BHA_OUT_S5;
      end
      BHA_S6: begin
        w = `BHA_OUT_S6;
      end
      default: begin
        w = `BHA_OUT_S0;
      end
    endcase
    return w;
  endfunction

  // fresh request with nobody confirming
  function automatic logic fresh_req(
    input logic w,
    input logic c
  );
    return w && !c;
  endfunction

  // nobody requesting and nobody confirming
  function automatic logic all_quiet(
    input logic w,
    input logic c
  );
    return !w && !c;
  endfunction

  // grant phase ends when want drops or owner confirms
  function automatic logic grant_done(
    input logic w,
    input logic c
  );
    return !w || c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state and output word

  bha_core_t c_q;
  bha_core_t c_d;

  logic      want;
  logic      conf;

  assign want = bus_want_in;
  assign conf = master_confirm_in;

  always_comb begin
    c_d = c_q;
    if (step_en) begin
      // if-chains keep the listed branch order
      case (c_q.state)
        BHA_S0: begin
          if (fresh_req(want, conf)) begin
            c_d.state = BHA_S1;
            c_d.word  = word_of(BHA_S1);
          end else if (conf) begin
            c_d.state = BHA_S5;
            c_d.word  = word_of(BHA_S5);
          end else begin
            c_d.state = BHA_S0;
            c_d.word  = word_of(BHA_S0);
          end
        end
        BHA_S1: begin
          c_d.state = BHA_S2;
          c_d.word  = word_of(BHA_S2);
        end
        BHA_S2: begin
          if (grant_done(want, conf)) begin
            c_d.state = BHA_S6;
            c_d.word  = word_of(BHA_S6);
          end else begin
            c_d.state = BHA_S2;
            c_d.word  = word_of(BHA_S2);
          end
        end
        BHA_S3: begin
          if (!want) begin
            c_d.state = BHA_S6;
            c_d.word  = word_of(BHA_S6);
          end else if (fresh_req(want, conf)) begin
            c_d.state = BHA_S2;
            c_d.word  = word_of(BHA_S2);
          end else begin
            c_d.state = BHA_S3;
            c_d.word  = word_of(BHA_S3);
          end
        end
        BHA_S4: begin
          c_d.state = BHA_S3;
          c_d.word  = word_of(BHA_S3);
        end
        BHA_S5: begin
          if (want) begin
            c_d.state = BHA_S4;
            c_d.word  = word_of(BHA_S4);
          end else if (all_quiet(want, conf)) begin
            c_d.state = BHA_S0;
            c_d.word  = word_of(BHA_S0);
          end else begin
            c_d.state = BHA_S5;
            c_d.word  = word_of(BHA_S5);
          end
        end
        BHA_S6: begin
          c_d.state = BHA_S5;
          c_d.word  = word_of(BHA_S5);
        end
        default: begin
          c_d.state = BHA_S0;
          c_d.word  = word_of(BHA_S0);
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_q.state <= BHA_S0;
      c_q.word  <= `BHA_OUT_RST;
    end else begin
      c_q <= c_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the word register

  assign bus_award_out  = c_q.word[`BHA_BIT_AWARD];
  assign host_float_out = c_q.word[`BHA_BIT_FLOAT];
  assign phase_flag_0   = c_q.word[`BHA_BIT_FLAG0];
  assign phase_flag_1   = c_q.word[`BHA_BIT_FLAG1];
  assign phase_flag_2   = c_q.word[`BHA_BIT_FLAG2];
  assign phase_flag_3   = c_q.word[`BHA_BIT_FLAG3];
  assign phase_flag_4   = c_q.word[`BHA_BIT_FLAG4];
  assign phase_flag_5   = c_q.word[`BHA_BIT_FLAG5];
  assign phase_flag_6   = c_q.word[`BHA_BIT_FLAG6];

endmodule // bha_arbiter

// [verification/bha_arb_monitor.sv]
// checker of the arbiter ports
// bound into bha_arbiter
`timescale 1ns/100ps
module bha_arb_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // master handshake
  input wire logic bus_want_in,
  input wire logic master_confirm_in,
  // grant and float
  input wire logic bus_award_out,
  input wire logic host_float_out,
  // state indicators
  input wire logic phase_flag_0,
  input wire logic phase_flag_1,
  input wire logic phase_flag_2,
  input wire logic phase_flag_3,
  input wire logic phase_flag_4,
  input wire logic phase_flag_5,
  input wire logic phase_flag_6
);
  wire [6:0] f = {phase_flag_0, phase_flag_1, phase_flag_2,
    phase_flag_3, phase_flag_4, phase_flag_5, phase_flag_6};
  wire [8:0] w = {bus_award_out, host_float_out, f};
  // request with nobody confirming
  wire       fresh = bus_want_in && !master_confirm_in;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold;
    $stable(w)[*3];
  endsequence
  a_reset_idle: assert property ($rose(rst_n) |-> w == 9'h040)
    else $error("idle");
  a_flag_onehot: assert property ($onehot(f))
    else $error("onehot");
  a_word_holds: assert property ($changed(w) |=> s_hold)
    else $error("hold");
  a_float_idle: assert property (!host_float_out |-> phase_flag_0)
    else $error("float");
  a_grant_cause: assert property ($rose(phase_flag_1) |->
    $past(fresh)) else $error("s1");
  a_grant_walk: assert property ($rose(phase_flag_1) |->
    ##4 w == 9'h190) else $error("s2");
  a_rearb_walk: assert property ($rose(phase_flag_4) |->
    ##4 w == 9'h188) else $error("s3");
  a_ack_walk: assert property ($rose(phase_flag_6) |->
    ##4 w == 9'h082) else $error("s5");
endmodule // bha_arb_monitor

bind bha_arbiter bha_arb_monitor u_mon(.clk, .rst_n, .bus_want_in,
  .master_confirm_in, .bus_award_out, .host_float_out, .phase_flag_0,
  .phase_flag_1, .phase_flag_2, .phase_flag_3, .phase_flag_4,
  .phase_flag_5, .phase_flag_6);

// [verification/bha_master_model.sv]
// bus master model
// confirms on award, releases on rel
`timescale 1ns/100ps
module bha_master_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // arbiter side
  input  wire logic award,
  // scenario controls
  input  wire logic req,
  input  wire logic rel,
  input  wire logic early,
  // master lines
  output logic      want,
  output logic      conf
);
  assign want = req;
  // early: master still confirming from before
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conf <= 1'b0;
    end else begin
      conf <= !rel && (conf || award || early);
    end
  end
endmodule // bha_master_model

// [verification/tb.sv]
// bench of the bus handoff arbiter
// far side is bha_master_model
`timescale 1ns/100ps
module tb;
  logic       clk = 0, rst_n = 0, req = 0, rel = 1, early = 0;
  logic       want, conf, aw, fl;
  logic [6:0] f;
  int         errors = 0, samples_checked = 0;
  always #5 clk = ~clk;
  bha_arbiter u_dut(.clk, .rst_n, .bus_want_in(want),
    .master_confirm_in(conf), .bus_award_out(aw), .host_float_out(fl),
    .phase_flag_0(f[6]), .phase_flag_1(f[5]), .phase_flag_2(f[4]),
    .phase_flag_3(f[3]), .phase_flag_4(f[2]), .phase_flag_5(f[1]),
    .phase_flag_6(f[0]));
  bha_master_model u_mst(.clk, .rst_n, .award(aw), .req, .rel, .early,
    .want, .conf);
  task automatic chk(input logic [8:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  // one 4-clock step, then compare the word
  task automatic st(input logic r, l, input logic [8:0] e);
    req = r;
    rel = l;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({aw, fl, f}, e);
  endtask
  task t_single;
    st(1, 0, 9'h1a0);
    st(1, 0, 9'h190);
    st(1, 0, 9'h081);
    st(0, 0, 9'h082);
    st(0, 0, 9'h082);
    st(0, 1, 9'h040);
  endtask
  task t_second;
    st(1, 1, 9'h1a0);
    st(1, 1, 9'h190);
    st(1, 1, 9'h190);
    st(1, 0, 9'h081);
    st(1, 0, 9'h082);
    st(1, 0, 9'h184);
    st(1, 0, 9'h188);
    st(1, 0, 9'h188);
    st(1, 1, 9'h190);
    st(0, 1, 9'h081);
    st(0, 1, 9'h082);
    st(0, 1, 9'h040);
  endtask
  task t_early;
    st(0, 1, 9'h040);
    early = 1;
    st(1, 0, 9'h082);
    early = 0;
    st(1, 0, 9'h184);
    st(1, 0, 9'h188);
    st(0, 0, 9'h081);
    st(0, 1, 9'h082);
    st(0, 1, 9'h040);
  endtask
  // async reset in mid-grant, divider restarts on release
  task t_reset;
    st(1, 0, 9'h1a0);
    rst_n = 0;
    repeat (2) @(negedge clk);
    chk({aw, fl, f}, 9'h040);
    rst_n = 1;
    st(1, 1, 9'h1a0);
  endtask
  task complete_run;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    chk({aw, fl, f}, 9'h040);
    t_single;
    t_second;
    t_early;
    t_reset;
    complete_run;
  end
  initial begin
    #5000;
    errors++;
    complete_run;
  end
endmodule // tb
